// *** rtl/hpc_port_cfg.sv ***
// Function
// - two-bit field picks over-current filter delay: 0.1, 4, 8 or 16 ms
// - compound flag set makes hub report itself as part of compound device
// - with strap configuration, any non-removable port makes the hub compound
// - renumber mode bit: 0 standard mode, 1 re-map mode
// - fixed-port mask bits 1 and 2 mark ports 1 and 2 non-removable
// - both masks hold bit 3 at one, bits 0 and 7:4 at zero
// - hub reports which active ports hold a permanently attached device
// - default configuration takes non-removable ports from the strap pins
// - port-off mask bits 1 and 2 disable ports 1 and 2
// - self-powered standard mode keeps masked ports disabled, never enumerated
// - hub reports only enabled port count and renumbers remaining ports
// - any combination of disabled ports is accepted, in any order
`timescale 1ns/1ps
`include "hpc_consts.svh"

module hpc_port_cfg
   import hpc_pkg::*;
#(
   parameter int unsigned OC_CYC0 = `HPC_OC_T0_US * `HPC_CLK_MHZ,
   parameter int unsigned OC_CYC1 = `HPC_OC_T1_US * `HPC_CLK_MHZ,
   parameter int unsigned OC_CYC2 = `HPC_OC_T2_US * `HPC_CLK_MHZ,
   parameter int unsigned OC_CYC3 = `HPC_OC_T3_US * `HPC_CLK_MHZ
)
(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_ce,
   input  hpc_cfg_wr_t      i_cfg,
   input  wire logic [7:0]  i_rd_addr,
   input  wire logic        i_use_default,
   input  wire logic [1:0]  i_fixed_port_strap_pins,
   input  wire logic [1:0]  i_port_off_strap_pins,
   input  wire logic        i_self_powered,
   input  wire logic [1:0]  i_overcurrent,
   output logic [7:0]       o_rd_data,
   output hpc_status_t      o_status,
   output logic [1:0]       o_overcurrent_valid
);

   localparam int unsigned CW = `HPC_OC_CNT_W;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // loads may not disturb the fixed bits of a port mask
   function automatic logic [7:0] hpc_fix_mask(input logic [7:0] v);
      hpc_fix_mask = (v & `HPC_MASK_KEEP) | `HPC_MASK_ONES;
   endfunction

   function automatic logic [1:0] hpc_count2(input logic [1:0] v);
      hpc_count2 = {1'b0, v[0]} + {1'b0, v[1]};
   endfunction

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   logic [7:0] cfg2_q;
   logic [7:0] cfg3_q;
   logic [7:0] fixed_q;
   logic [7:0] off_q;
   logic       wr_cfg2;
   logic       wr_cfg3;
   logic       wr_fixed;
   logic       wr_off;

   // write decode
   assign wr_cfg2  = i_cfg.wr && (i_cfg.addr == `HPC_ADDR_CFG2);
   assign wr_cfg3  = i_cfg.wr && (i_cfg.addr == `HPC_ADDR_CFG3);
   assign wr_fixed = i_cfg.wr && (i_cfg.addr == `HPC_ADDR_FIXED);
   assign wr_off   = i_cfg.wr && (i_cfg.addr == `HPC_ADDR_PORT_OFF);

   // loads from eeprom or smbus host
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cfg2_q  <= `HPC_CFG2_RST;
         cfg3_q  <= `HPC_CFG3_RST;
         fixed_q <= `HPC_MASK_RST;
         off_q   <= `HPC_MASK_RST;
      end
      else if (i_ce)
      begin
         if (wr_cfg2)
            cfg2_q <= i_cfg.data;
         if (wr_cfg3)
            cfg3_q <= i_cfg.data;
         if (wr_fixed)
            fixed_q <= hpc_fix_mask(i_cfg.data);
         if (wr_off)
            off_q <= hpc_fix_mask(i_cfg.data);
      end
   end

   // ----------------------------------------
   // read-back
   // ----------------------------------------
   logic [7:0] rd_d;
   logic [7:0] rd_q;

   // unmapped offsets read as zero
   assign rd_d = (i_rd_addr == `HPC_ADDR_CFG2)     ? cfg2_q  :
                 (i_rd_addr == `HPC_ADDR_CFG3)     ? cfg3_q  :
                 (i_rd_addr == `HPC_ADDR_FIXED)    ? fixed_q :
                 (i_rd_addr == `HPC_ADDR_PORT_OFF) ? off_q   : 8'h00;

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         rd_q <= 8'h00;
      else if (i_ce)
         rd_q <= rd_d;
   end

   assign o_rd_data = rd_q;

   // ----------------------------------------
   // effective port configuration
   // ----------------------------------------
   logic [1:0] fixed_eff;
   logic [1:0] off_eff;
   logic [1:0] off_applied;
   logic [1:0] enabled;
   logic       compound;
   logic       renum_mode;
   logic [1:0] lp1;
   logic [1:0] lp2;
   logic [1:0] nonrem_log;

   assign renum_mode = cfg3_q[`HPC_RENUM_BIT];
   assign fixed_eff  = i_use_default ? i_fixed_port_strap_pins
                                     : fixed_q[`HPC_PORT2_BIT:`HPC_PORT1_BIT];
   assign off_eff    = i_use_default ? i_port_off_strap_pins
                                     : off_q[`HPC_PORT2_BIT:`HPC_PORT1_BIT];
   // the loader is trusted to mark the hardwired ports itself
   assign compound   = i_use_default ? (|i_fixed_port_strap_pins)
                                     : cfg2_q[`HPC_COMPOUND_BIT];

   // re-map tables lie outside this block, so re-map mode keeps both ports up
   assign off_applied = (i_self_powered && !renum_mode) ? off_eff : 2'b00;
   assign enabled     = ~off_applied;

   // packed logical numbering: a surviving port 2 moves down when port 1 is off
   assign lp1 = enabled[0] ? 2'h1 : 2'h0;
   assign lp2 = !enabled[1] ? 2'h0 : (enabled[0] ? 2'h2 : 2'h1);

   // non-removable bits indexed by logical port, active ports only
   assign nonrem_log[0] = (enabled[0] && fixed_eff[0]) ||
                          (!enabled[0] && enabled[1] && fixed_eff[1]);
   assign nonrem_log[1] = enabled[0] && enabled[1] && fixed_eff[1];

   // status registered so the host side sees clean levels
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_status <= '0;
      else if (i_ce)
      begin
         o_status.compound       <= compound;
         o_status.num_ports      <= hpc_count2(enabled);
         o_status.enabled        <= enabled;
         o_status.logical_p1     <= lp1;
         o_status.logical_p2     <= lp2;
         o_status.nonrem_logical <= nonrem_log;
      end
   end

   // ----------------------------------------
   // over-current filtering
   // ----------------------------------------
   logic [CW-1:0] oc_limit;

   // code 00 is the short delay, others step 4, 8, 16 ms
   assign oc_limit = (cfg2_q[`HPC_OC_DLY_HI:`HPC_OC_DLY_LO] == 2'b00) ? CW'(OC_CYC0) :
                     (cfg2_q[`HPC_OC_DLY_HI:`HPC_OC_DLY_LO] == 2'b01) ? CW'(OC_CYC1) :
                     (cfg2_q[`HPC_OC_DLY_HI:`HPC_OC_DLY_LO] == 2'b10) ? CW'(OC_CYC2) :
                                                                         CW'(OC_CYC3);

   for (genvar p = 0; p < 2; p++)
   begin : g_oc
      hpc_oc_filter #(.CNT_W(CW)) u_filt
      (
         .i_clk    (i_clk),
         .i_resetn (i_resetn),
         .i_ce     (i_ce),
         .i_raw    (i_overcurrent[p]),
         .i_limit  (oc_limit),
         .o_valid  (o_overcurrent_valid[p])
      );
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_OC_CODE_MAP: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (cfg2_q[5:4] == 2'b11) |-> (oc_limit == CW'(OC_CYC3)) && (oc_limit > CW'(OC_CYC2)))
      else $error("over-current delay code mismatch");

   AST_COMPOUND_CFG: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && !i_use_default) |=> (o_status.compound == $past(cfg2_q[3])))
      else $error("compound report differs from flag");

   AST_COMPOUND_STRAP: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && i_use_default && (|i_fixed_port_strap_pins)) |=> o_status.compound)
      else $error("strap non-removable port did not make hub compound");

   AST_MASK_FIXED_BITS: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (fixed_q[3] && !fixed_q[0] && (fixed_q[7:4] == 4'h0)) &&
      (off_q[3] && !off_q[0] && (off_q[7:4] == 4'h0)))
      else $error("port mask fixed bits disturbed");

   AST_PORT_STAYS_OFF: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && i_self_powered && !renum_mode && off_eff[0]) |=> !o_status.enabled[0] && (o_status.logical_p1 == 2'h0))
      else $error("disabled port still enabled");

   AST_PORT_COUNT: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_ce |=> (o_status.num_ports == (2'h2 - hpc_count2($past(off_applied)))))
      else $error("reported port count wrong");

   AST_RENUMBER: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && (off_applied == 2'b01)) |=> (o_status.logical_p2 == 2'h1))
      else $error("port 2 not renumbered to 1");

   AST_NONREM_REPORT: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && (enabled == 2'b11) && fixed_eff[1]) |=> o_status.nonrem_logical[1])
      else $error("non-removable port not reported");

   AST_REMAP_MODE: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && renum_mode) |=> (o_status.enabled == 2'b11))
      else $error("standard disable applied in re-map mode");

endmodule

// *** rtl/hpc_consts.svh ***
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// ----------------------------------------
// register offsets on the configuration load port
// ----------------------------------------
`define HPC_ADDR_CFG2      8'h07
`define HPC_ADDR_CFG3      8'h08
`define HPC_ADDR_FIXED     8'h09
`define HPC_ADDR_PORT_OFF  8'h0a

// ----------------------------------------
// field positions
// ----------------------------------------
`define HPC_OC_DLY_HI      5
`define HPC_OC_DLY_LO      4
`define HPC_COMPOUND_BIT   3
`define HPC_RENUM_BIT      3
`define HPC_PORT1_BIT      1
`define HPC_PORT2_BIT      2

// ----------------------------------------
// reset values and fixed-bit masks of the port masks
// ----------------------------------------
`define HPC_CFG2_RST       8'h00
`define HPC_CFG3_RST       8'h00
`define HPC_MASK_RST       8'h08
`define HPC_MASK_KEEP      8'h06
`define HPC_MASK_ONES      8'h08

// ----------------------------------------
// over-current filter delays, in microseconds, and clock rate
// ----------------------------------------
`define HPC_CLK_MHZ        125
`define HPC_OC_T0_US       100
`define HPC_OC_T1_US       4000
`define HPC_OC_T2_US       8000
`define HPC_OC_T3_US       16000
`define HPC_OC_CNT_W       21

`endif

// *** rtl/hpc_pkg.sv ***
package hpc_pkg;

   // one load from the configuration source
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } hpc_cfg_wr_t;

   // what the hub core reports to the host side
   typedef struct packed {
      logic       compound;
      logic [1:0] num_ports;
      logic [1:0] enabled;
      logic [1:0] logical_p1;
      logic [1:0] logical_p2;
      logic [1:0] nonrem_logical;
   } hpc_status_t;

endpackage

// *** rtl/hpc_oc_filter.sv ***
`timescale 1ns/1ps
`include "hpc_consts.svh"

module hpc_oc_filter
   import hpc_pkg::*;
#(
   parameter int unsigned CNT_W = `HPC_OC_CNT_W
)
(
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   input  wire logic             i_ce,
   input  wire logic             i_raw,
   input  wire logic [CNT_W-1:0] i_limit,
   output logic                  o_valid
);

   // ----------------------------------------
   // qualification counter
   // ----------------------------------------
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             hit;
   logic             valid_q;

   // a dropout restarts the count, so only unbroken pulses qualify
   assign hit   = (cnt_q >= (i_limit - CNT_W'(1)));
   assign cnt_d = !i_raw ? '0 : (hit ? cnt_q : cnt_q + CNT_W'(1));

   // count and flag advance together
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cnt_q   <= '0;
         valid_q <= 1'b0;
      end
      else if (i_ce)
      begin
         cnt_q   <= cnt_d;
         valid_q <= i_raw && hit;
      end
   end

   assign o_valid = valid_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_OC_SHORT_IGNORED: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && !i_raw) |=> !o_valid)
      else $error("over-current flag set while input low");

   AST_OC_RISE_AFTER_DELAY: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(o_valid) |-> ($past(cnt_q) >= ($past(i_limit) - CNT_W'(1))))
      else $error("over-current flag set before filter delay");

endmodule

// *** tb/hpc_cfg_loader.sv ***
`timescale 1ns/1ps

module hpc_cfg_loader
   import hpc_pkg::*;
(
   input  wire logic   i_clk,
   output hpc_cfg_wr_t o_cfg
);
   initial o_cfg = '0;

   // ----------------------------------------
   // byte loads, launched off the falling edge
   // ----------------------------------------
   // one strobe per byte; the released bus shows inverted values, never stale ones
   task automatic load_byte(input logic [7:0] addr, input logic [7:0] data);
      @(negedge i_clk);
      o_cfg = {1'b1, addr, data};
      @(negedge i_clk);
      o_cfg = {1'b0, ~addr, ~data};
   endtask

   // masks always carry bit 3 set and bits 0 and 7:4 clear
   task automatic load_mask(input logic [7:0] addr, input logic [1:0] ports);
      load_byte(addr, {4'h0, 1'b1, ports, 1'b0});
   endtask

   // compound flag never goes out without its non-removable ports
   task automatic load_compound(input logic [1:0] dly, input logic [1:0] ports);
      load_byte(8'h07, {2'h0, dly, |ports, 3'h0});
      load_mask(8'h09, ports);
   endtask
endmodule

// *** tb/hpc_port_cfg_tb.sv ***
`timescale 1ns/1ps
`include "hpc_consts.svh"

module hpc_port_cfg_tb
   import hpc_pkg::*;
;
   // short filter counts keep the run small
   localparam int unsigned CYC [4] = '{4, 8, 12, 16};
   logic        i_clk;
   logic        i_resetn;
   logic        i_ce;
   logic        i_use_default;
   logic        i_self_powered;
   logic [7:0]  i_rd_addr;
   logic [7:0]  o_rd_data;
   logic [1:0]  fx_strap;
   logic [1:0]  off_strap;
   logic [1:0]  i_overcurrent;
   logic [1:0]  o_overcurrent_valid;
   hpc_cfg_wr_t i_cfg;
   hpc_status_t o_status;
   int          bad_count;
   int          checks;

   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   hpc_cfg_loader u_hpc_cfg_loader (.i_clk(i_clk), .o_cfg(i_cfg));

   hpc_port_cfg #(.OC_CYC0(CYC[0]), .OC_CYC1(CYC[1]), .OC_CYC2(CYC[2]), .OC_CYC3(CYC[3])) u_hpc_port_cfg (
      .i_clk                   (i_clk),
      .i_resetn                (i_resetn),
      .i_ce                    (i_ce),
      .i_cfg                   (i_cfg),
      .i_rd_addr               (i_rd_addr),
      .i_use_default           (i_use_default),
      .i_fixed_port_strap_pins (fx_strap),
      .i_port_off_strap_pins   (off_strap),
      .i_self_powered          (i_self_powered),
      .i_overcurrent           (i_overcurrent),
      .o_rd_data               (o_rd_data),
      .o_status                (o_status),
      .o_overcurrent_valid     (o_overcurrent_valid)
   );

   // ----------------------------------------
   // compares, reads and expected status
   // ----------------------------------------
   task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic cmp_st(input hpc_status_t exp);
      checks++;
      if (o_status !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, o_status);
      end
   endtask

   // read data lands one enabled edge after the address
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      @(negedge i_clk);
      i_rd_addr = addr;
      @(negedge i_clk);
      cmp8(exp, o_rd_data);
   endtask

   // off is the disable set that really applies; survivors are packed from logical port 1 up
   function automatic hpc_status_t exp_st(input logic cmp, input logic [1:0] fx, input logic [1:0] off);
      hpc_status_t s;
      s.compound       = cmp;
      s.enabled        = ~off;
      s.num_ports      = {1'b0, s.enabled[0]} + {1'b0, s.enabled[1]};
      s.logical_p1     = s.enabled[0] ? 2'h1 : 2'h0;
      s.logical_p2     = s.enabled[1] ? (s.enabled[0] ? 2'h2 : 2'h1) : 2'h0;
      s.nonrem_logical = 2'h0;
      if (s.enabled[0] && fx[0])
         s.nonrem_logical[0] = 1'b1;
      if (s.enabled[1] && fx[1])
         s.nonrem_logical[s.logical_p2 - 2'h1] = 1'b1;
      return s;
   endfunction

   // registers settle on one edge, status on the next
   task automatic st_chk(input hpc_status_t exp);
      repeat (2) @(negedge i_clk);
      cmp_st(exp);
   endtask

   task automatic end_sim;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // hang guard: far beyond the longest sequence
   initial
   begin
      #200000;
      bad_count++;
      end_sim();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      logic [1:0] ord [4];
      logic [1:0] p;
      ord = '{2'h2, 2'h1, 2'h3, 2'h0};
      {i_resetn, i_ce, i_use_default, i_self_powered} = 4'h5;
      {fx_strap, off_strap, i_overcurrent} = 6'h00;
      i_rd_addr = 8'h00;
      bad_count = 0;
      checks = 0;
      repeat (2) @(negedge i_clk);
      i_resetn = 1'b1;
      rd(`HPC_ADDR_CFG2, `HPC_CFG2_RST);
      rd(`HPC_ADDR_CFG3, `HPC_CFG3_RST);
      rd(`HPC_ADDR_FIXED, `HPC_MASK_RST);
      rd(`HPC_ADDR_PORT_OFF, `HPC_MASK_RST);
      rd(8'h0b, 8'h00);
      cmp_st(exp_st(1'b0, 2'h0, 2'h0));
      // a load while the clock enable is low is lost
      i_ce = 1'b0;
      u_hpc_cfg_loader.load_byte(`HPC_ADDR_CFG2, 8'h30);
      i_ce = 1'b1;
      rd(`HPC_ADDR_CFG2, 8'h00);
      u_hpc_cfg_loader.load_byte(`HPC_ADDR_FIXED, 8'hff);
      rd(`HPC_ADDR_FIXED, 8'h0e);
      u_hpc_cfg_loader.load_byte(`HPC_ADDR_PORT_OFF, 8'hf1);
      rd(`HPC_ADDR_PORT_OFF, 8'h08);
      // re-map mode ignores the off mask
      u_hpc_cfg_loader.load_byte(`HPC_ADDR_CFG3, 8'h08);
      u_hpc_cfg_loader.load_mask(`HPC_ADDR_PORT_OFF, 2'h3);
      st_chk(exp_st(1'b0, 2'h3, 2'h0));
      u_hpc_cfg_loader.load_byte(`HPC_ADDR_CFG3, 8'h00);
      st_chk(exp_st(1'b0, 2'h3, 2'h3));
      // every disable combination, out of order, with varying fixed ports
      foreach (ord[i])
      begin
         u_hpc_cfg_loader.load_compound(2'h0, ord[i] ^ 2'h1);
         u_hpc_cfg_loader.load_mask(`HPC_ADDR_PORT_OFF, ord[i]);
         st_chk(exp_st(|(ord[i] ^ 2'h1), ord[i] ^ 2'h1, ord[i]));
      end
      // bus-powered keeps every port regardless of the self-powered mask
      u_hpc_cfg_loader.load_mask(`HPC_ADDR_PORT_OFF, 2'h1);
      i_self_powered = 1'b0;
      // the last compound load left the flag set with port 1 fixed
      st_chk(exp_st(1'b1, 2'h1, 2'h0));
      i_self_powered = 1'b1;
      // straps replace register contents in the default configuration
      i_use_default = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         fx_strap = 2'(k);
         off_strap = 2'(k) ^ 2'h2;
         st_chk(exp_st(k != 0, 2'(k), 2'(k) ^ 2'h2));
      end
      i_use_default = 1'b0;
      // each filter delay: a pulse one sample short is ignored, the full count is not
      for (int k = 0; k < 4; k++)
      begin
         p = k[0] ? 2'h2 : 2'h1;
         u_hpc_cfg_loader.load_byte(`HPC_ADDR_CFG2, {2'h0, 2'(k), 4'h0});
         rd(`HPC_ADDR_CFG2, {2'h0, 2'(k), 4'h0});
         i_overcurrent = p;
         repeat (CYC[k] - 1) @(negedge i_clk);
         cmp8(8'h00, {6'h00, o_overcurrent_valid});
         i_overcurrent = 2'h0;
         @(negedge i_clk);
         i_overcurrent = p;
         repeat (CYC[k] - 1) @(negedge i_clk);
         cmp8(8'h00, {6'h00, o_overcurrent_valid});
         @(negedge i_clk);
         cmp8({6'h00, p}, {6'h00, o_overcurrent_valid});
         i_overcurrent = 2'h0;
         @(negedge i_clk);
         cmp8(8'h00, {6'h00, o_overcurrent_valid});
      end
      end_sim();
   end
endmodule
